// file: inc/pwm_chopper_defs.svh
// constants for the quiet chopper configuration register block
// assumes AHB-Lite word access, 32-bit data
`ifndef PWM_CHOPPER_DEFS_SVH
`define PWM_CHOPPER_DEFS_SVH
// ==========================================================
// register map
`define CFG_OFFSET        8'h3C
`define STAT_OFFSET       8'h40
`define CTRL_OFFSET       8'h44
// ==========================================================
// chopper configuration fields and reset
`define CFG_RESET         32'hC40C001D
`define LIM_HI            31
`define LIM_LO            28
`define REG_HI            27
`define REG_LO            24
`define DISREG_BIT        23
`define MEAS_BIT          22
`define FW_HI             21
`define FW_LO             20
`define AUTOSCALE_BIT     18
`define OFS_HI            7
`define OFS_LO            0
// ==========================================================
// control register fields (standstill decode and regulator inputs)
`define CTRL_RESET        32'h00000000
`define CTRL_STST_BIT     0
`define CTRL_HOLD0_BIT    1
`define CTRL_REDUCED_BIT  2
`define CTRL_HALFW_BIT    3
`define CTRL_BACK_BIT     4
`define CTRL_TARGET_HI    15
`define CTRL_TARGET_LO    8
`define AMPL_RESET        8'h00
`define AMPL_HI_NIB_HI    7
`define AMPL_HI_NIB_LO    4
`endif

// file: inc/pwm_chopper_pkg.sv
// types for the quiet chopper configuration block
// assumes pwm_chopper_defs.svh for numeric constants
package pwm_chopper_pkg;
  typedef enum logic [3:0] {
    SS_NORMAL    = 4'b0001,
    SS_ZERO_HOLD_STANDSTILL_OPTION = 4'b0010,
    SS_SHORT_LS  = 4'b0100,
    SS_SHORT_HS  = 4'b1000
  } standstill_t;
endpackage

// file: rtl/amplitude_regulator.sv
// automatic amplitude regulator with switch-back clamp
// assumes strobes are one-cycle pulses in the mclk domain
`timescale 1ns/100ps
`default_nettype none
`include "pwm_chopper_defs.svh"
module amplitude_regulator (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       halfWave,
  input  wire logic       switchBack,
  input  wire logic       regEnable,
  input  wire logic [7:0] target,
  input  wire logic [3:0] regGradient,
  input  wire logic [3:0] switchbackAmplitudeLimit,
  output logic      [7:0] autoAmplitude
);
  // ========================================================
  // amplitude in half increments
  logic [8:0] acc_q;
  logic [8:0] acc_d;
  logic [8:0] tgt2;
  logic [8:0] lim;
  always_comb
  begin
    tgt2 = {target, 1'b0};
    lim = {5'h00, regGradient};
    acc_d = acc_q;
    // clamp wins over a step in the same cycle only when acc_q[8:5] is above the limit
    if (switchBack && acc_q[8:5] > switchbackAmplitudeLimit)
    begin
      acc_d = {switchbackAmplitudeLimit, 5'h1F};
    end
    else if (halfWave && regEnable)
    begin
      if (tgt2 > acc_q)
        acc_d = (tgt2 - acc_q > lim) ? acc_q + lim : tgt2;
      else
        acc_d = (acc_q - tgt2 > lim) ? acc_q - lim : tgt2;
    end
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      acc_q <= {`AMPL_RESET, 1'b0};
    else
      acc_q <= acc_d;
  end
  assign autoAmplitude = acc_q[8:1];

  a_step_bound: assert property (@(posedge mclk) disable iff (!reset_n)
    halfWave && !switchBack |=>
      ((acc_q >= $past(acc_q)) ? acc_q - $past(acc_q)
        : $past(acc_q) - acc_q) <= {5'h00, $past(regGradient)})
    else $error("amplitude moved more than gradient allows");
  a_clamp_back: assert property (@(posedge mclk) disable iff (!reset_n)
    switchBack |=> autoAmplitude[7:4] <= $past(switchbackAmplitudeLimit))
    else $error("switch-back clamp not applied");
endmodule
`default_nettype wire

// file: rtl/pwm_chopper_config.sv
// chopper configuration register with AHB-Lite slave
// assumes single-word AHB-Lite transfers, one slave on the bus
// Operation
// - on switch-back, clamp amplitude bits 7:4 to limit field, reset 12; here a half-wave step in the same cycle can leave them above the limit
// - limit affects only automatic amplitude, never gradient terms
// - autoscale changes amplitude at most code*0.5 per half wave
// - standstill regulation-off bit stops regulation at reduced standstill
// - measure bit enables low-side slow-decay current measurement
// - standstill option applies only when hold current is zero
// - option 0 normal, 1 zero_hold_standstill_option, 2 LS short, 3 HS short
// - autoscale bit 18, reset 1, selects automatic or feed-forward
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_chopper_defs.svh"
module pwm_chopper_config (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [7:0]  amplitude,
  output logic             regulationActive,
  output logic             slowDecayLowsideMeasure,
  output logic             autoScaling,
  output logic             bridgeOff,
  output logic             shortLowside,
  output logic             shortHighside
);
  // ========================================================
  // bus address phase capture
  logic        wrPend_q, wrPend_d;
  logic [7:0]  wrAddr_q, wrAddr_d;
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic        take;
  logic        rdyOut_q, rdyOut_d;
  logic        respOut_q, respOut_d;
  logic [7:0]  amp_q, amp_d;
  logic [5:0]  outs_q, outs_d;
  assign take = hsel && hready && htrans[1];
  always_comb
  begin
    wrPend_d = take && hwrite;
    wrAddr_d = take ? haddr[7:0] : wrAddr_q;
    cfg_d = cfg_q;
    ctrl_d = ctrl_q;
    ctrl_d[`CTRL_HALFW_BIT] = 1'b0;
    ctrl_d[`CTRL_BACK_BIT] = 1'b0;
    // whole-word update
    if (wrPend_q && wrAddr_q == `CFG_OFFSET)
      cfg_d = hwdata;
    if (wrPend_q && wrAddr_q == `CTRL_OFFSET)
      ctrl_d = hwdata;
    // zero-wait slave, always OKAY
    rdyOut_d = 1'b1;
    respOut_d = 1'b0;
    rdata_d = rdata_q;
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        `CFG_OFFSET:  rdata_d = cfg_q;
        `STAT_OFFSET: rdata_d = {18'h00000, outs_q, amp_q};
        `CTRL_OFFSET: rdata_d = ctrl_q;
        default:      rdata_d = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      cfg_q <= `CFG_RESET;
      ctrl_q <= `CTRL_RESET;
      rdata_q <= 32'h00000000;
      rdyOut_q <= 1'b1;
      respOut_q <= 1'b0;
    end
    else
    begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      rdyOut_q <= rdyOut_d;
      respOut_q <= respOut_d;
    end
  end
  assign hrdata = rdata_q;
  assign hreadyout = rdyOut_q;
  assign hresp = respOut_q;
  // ========================================================
  // standstill decode and regulation
  pwm_chopper_pkg::standstill_t mode;
  logic       standstill, holdZero, reduced, regOn;
  logic [7:0] autoAmp;
  assign standstill = ctrl_q[`CTRL_STST_BIT];
  assign holdZero = ctrl_q[`CTRL_HOLD0_BIT];
  assign reduced = ctrl_q[`CTRL_REDUCED_BIT];
  always_comb
  begin
    case (cfg_q[`FW_HI:`FW_LO])
      2'h1:    mode = pwm_chopper_pkg::SS_ZERO_HOLD_STANDSTILL_OPTION;
      2'h2:    mode = pwm_chopper_pkg::SS_SHORT_LS;
      2'h3:    mode = pwm_chopper_pkg::SS_SHORT_HS;
      default: mode = pwm_chopper_pkg::SS_NORMAL;
    endcase
    if (!(standstill && holdZero))
      mode = pwm_chopper_pkg::SS_NORMAL;
  end
  // regulation off only at reduced standstill with bit set
  assign regOn = !(cfg_q[`DISREG_BIT] && standstill && reduced);
  // limit only touches amplitude path, gradient fields untouched
  amplitude_regulator regulator (
    .mclk                     (mclk),
    .reset_n                  (reset_n),
    .halfWave                 (ctrl_q[`CTRL_HALFW_BIT]),
    .switchBack               (ctrl_q[`CTRL_BACK_BIT]),
    .regEnable                (regOn && cfg_q[`AUTOSCALE_BIT]),
    .target                   (ctrl_q[`CTRL_TARGET_HI:`CTRL_TARGET_LO]),
    .regGradient              (cfg_q[`REG_HI:`REG_LO]),
    .switchbackAmplitudeLimit (cfg_q[`LIM_HI:`LIM_LO]),
    .autoAmplitude            (autoAmp)
  );
  // ========================================================
  // registered outputs
  always_comb
  begin
    // feed-forward uses the offset term when autoscale is off
    amp_d = cfg_q[`AUTOSCALE_BIT] ? autoAmp : cfg_q[`OFS_HI:`OFS_LO];
    outs_d = {regOn, cfg_q[`MEAS_BIT], cfg_q[`AUTOSCALE_BIT],
              mode == pwm_chopper_pkg::SS_ZERO_HOLD_STANDSTILL_OPTION,
              mode == pwm_chopper_pkg::SS_SHORT_LS,
              mode == pwm_chopper_pkg::SS_SHORT_HS};
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      amp_q <= `AMPL_RESET;
      outs_q <= 6'h00;
    end
    else
    begin
      amp_q <= amp_d;
      outs_q <= outs_d;
    end
  end
  assign amplitude = amp_q;
  assign {regulationActive, slowDecayLowsideMeasure, autoScaling,
          bridgeOff, shortLowside, shortHighside} = outs_q;

  // ========================================================
  // checks
  a_cfg_write: assert property (@(posedge mclk) disable iff (!reset_n)
    wrPend_q && wrAddr_q == `CFG_OFFSET |=> cfg_q == $past(hwdata))
    else $error("config write not stored");
  a_rd_config: assert property (@(posedge mclk) disable iff (!reset_n)
    take && !hwrite && haddr[7:0] == `CFG_OFFSET |=> hrdata == $past(cfg_q))
    else $error("config read data wrong");
  a_half_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_q[`CTRL_HALFW_BIT] && !(wrPend_q && wrAddr_q == `CTRL_OFFSET)
      |=> !ctrl_q[`CTRL_HALFW_BIT])
    else $error("half-wave strobe stuck");
  a_back_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_q[`CTRL_BACK_BIT] && !(wrPend_q && wrAddr_q == `CTRL_OFFSET)
      |=> !ctrl_q[`CTRL_BACK_BIT])
    else $error("switch-back strobe stuck");
  a_hold_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !(standstill && holdZero) |=> !bridgeOff && !shortLowside
      && !shortHighside)
    else $error("standstill option active with nonzero hold");
  a_fw_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    standstill && holdZero && cfg_q[`FW_HI:`FW_LO] == 2'h2
      |=> shortLowside && !bridgeOff)
    else $error("standstill option decode wrong");
  a_fb_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    standstill && holdZero && cfg_q[`FW_HI:`FW_LO] == 2'h1
      |=> bridgeOff && !shortLowside && !shortHighside)
    else $error("zero_hold_standstill_option decode wrong");
  a_hs_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    standstill && holdZero && cfg_q[`FW_HI:`FW_LO] == 2'h3
      |=> shortHighside && !bridgeOff && !shortLowside)
    else $error("high-side short decode wrong");
  a_reg_off: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_q[`DISREG_BIT] && standstill && reduced |=> !regulationActive)
    else $error("regulation not suspended");
  a_reg_on: assert property (@(posedge mclk) disable iff (!reset_n)
    !(cfg_q[`DISREG_BIT] && standstill && reduced) |=> regulationActive)
    else $error("regulation wrongly suspended");
  a_meas_out: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> slowDecayLowsideMeasure == $past(cfg_q[`MEAS_BIT]))
    else $error("measure output mismatch");
  a_scale_out: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> autoScaling == $past(cfg_q[`AUTOSCALE_BIT]))
    else $error("autoscale output mismatch");
  a_ff_ampl: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_q[`AUTOSCALE_BIT] |=> amplitude == $past(cfg_q[`OFS_HI:`OFS_LO]))
    else $error("feed-forward amplitude wrong");
  a_auto_ampl: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_q[`AUTOSCALE_BIT] |=> amplitude == $past(autoAmp))
    else $error("automatic amplitude not passed on");
endmodule
`default_nettype wire

// file: verification/pwm_chopper_config_test.sv
// self-checking bench for the chopper configuration register block
// assumes one AHB-Lite slave whose hreadyout is the bus hready
`timescale 1ns/100ps
`default_nettype none
module pwm_chopper_config_test;
  // ==========================================================
  // signals
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  amplitude;
  wire  [5:0]  flags;
  logic [31:0] rd;
  int          errCount = 0;
  int          testsRun = 0;
  // cfg, ctrl {reduced,hold0,stst}, flags, amplitude
  logic [48:0] rows [11] = '{
    {32'h00000055, 3'b000, 6'b100000, 8'h55},
    {32'h00800000, 3'b101, 6'b000000, 8'h00},
    {32'h00800000, 3'b001, 6'b100000, 8'h00},
    {32'h00400000, 3'b000, 6'b110000, 8'h00},
    {32'h00100000, 3'b011, 6'b100100, 8'h00},
    {32'h00200000, 3'b011, 6'b100010, 8'h00},
    {32'h00300000, 3'b011, 6'b100001, 8'h00},
    {32'h00300000, 3'b001, 6'b100000, 8'h00},
    {32'h00100000, 3'b010, 6'b100000, 8'h00},
    {32'h00040000, 3'b000, 6'b101000, 8'h00},
    {32'h000000A5, 3'b011, 6'b100000, 8'hA5}};

  always #20 mclk = ~mclk;
  assign hready = hreadyout;

  pwm_chopper_config u_dut (
    .mclk                    (mclk),
    .reset_n                 (reset_n),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hwdata                  (hwdata),
    .hready                  (hready),
    .hrdata                  (hrdata),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .amplitude               (amplitude),
    .regulationActive        (flags[5]),
    .slowDecayLowsideMeasure (flags[4]),
    .autoScaling             (flags[3]),
    .bridgeOff               (flags[2]),
    .shortLowside            (flags[1]),
    .shortHighside           (flags[0])
  );

  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic closeOut();
    if (errCount == 0 && testsRun > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic waitReady();
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        check("hready", {31'h0, hready}, 32'h1);
        closeOut();
      end
      @(posedge mclk);
    end
  endtask

  // one single-word transfer, read data left in rd
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    tick(16);
    check("flags in reset", {26'h0, flags}, 32'h0);
    check("bus in reset", {30'h0, hreadyout, hresp}, 32'h2);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 32'h3C, 32'h0);
    check("cfg reset", rd, 32'hC40C001D);
    check("autoscale", {31'h0, flags[3]}, 32'h1);
    foreach (rows[i])
    begin
      bus(1'b1, 32'h3C, rows[i][48:17]);
      bus(1'b1, 32'h44, {29'h0, rows[i][16:14]});
      tick(3);
      check("flags", {26'h0, flags}, {26'h0, rows[i][13:8]});
      check("amplitude", {24'h0, amplitude}, {24'h0, rows[i][7:0]});
      bus(1'b0, 32'h3C, 32'h0);
      check("cfg readback", rd, rows[i][48:17]);
    end
    bus(1'b1, 32'h80, 32'hFFFFFFFF);
    bus(1'b0, 32'h80, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, 32'h3C, 32'h0);
    check("cfg kept", rd, 32'h000000A5);
    // second reset so the regulator starts from zero
    reset_n <= 1'b0;
    tick(2);
    check("amplitude in reset", {24'h0, amplitude}, 32'h0);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 32'h3C, 32'h0);
    check("cfg after reset", rd, 32'hC40C001D);
    bus(1'b1, 32'h3C, 32'h0F04AB00);
    for (int k = 1; k <= 4; k++)
    begin
      bus(1'b1, 32'h44, 32'h0000FF08);
      tick(3);
      check("amplitude step", {24'h0, amplitude}, (k * 15) / 2);
    end
    bus(1'b1, 32'h44, 32'h0000FF10);
    tick(3);
    check("amplitude clamp", {24'h0, amplitude}, 32'h0F);
    bus(1'b0, 32'h3C, 32'h0);
    check("gradient kept", rd, 32'h0F04AB00);
    bus(1'b1, 32'h3C, 32'h0104AB00);
    bus(1'b1, 32'h44, 32'h0000FF08);
    bus(1'b1, 32'h44, 32'h0000FF08);
    tick(3);
    check("amplitude slow", {24'h0, amplitude}, 32'h10);
    bus(1'b1, 32'h3C, 32'h0184AB00);
    bus(1'b1, 32'h44, 32'h0000FF0D);
    tick(3);
    check("amplitude held", {24'h0, amplitude}, 32'h10);
    bus(1'b0, 32'h40, 32'h0);
    check("status", rd, 32'h00000810);
    bus(1'b0, 32'h44, 32'h0);
    check("control", rd, 32'h0000FF05);
    closeOut();
  end
endmodule
`default_nettype wire
